// ===== include/slpa_defs.vh
// Purpose: Constants for the stack limit and program space addressing block
// Assumes: 16-bit byte-addressed data space, 24-bit program space
// Notes:   Included by rtl/slpa_addr_unit.v and rtl/slpa_region_map.v
`ifndef SLPA_DEFS_VH
`define SLPA_DEFS_VH

// Special function register region bounds
`define SLPA_REG_LO        16'h0000
`define SLPA_REG_HI        16'h07ff
// Stack underflow floor
`define SLPA_STACK_FLOOR   16'h0800
// Region granule: aligned 32-byte blocks, index is addr[10:5]
`define SLPA_REGION_LSB    5
`define SLPA_REGION_MSB    10
`define SLPA_REGION_CNT    64
// Visibility select bit of an effective address
`define SLPA_VIS_BIT       15
// Table page bit selecting configuration memory
`define SLPA_CFG_BIT       7
// Reset values
`define SLPA_SP_RST        16'h0800
`define SLPA_PAGE_RST      8'h00
// Stack word step in bytes
`define SLPA_WORD_STEP     16'h0002

`endif

// ===== rtl/slpa_addr_unit.v
// Purpose: Data-space address support: register region decode, software
//          stack pointer with limit and floor checks, and program-space
//          address forming for table and visibility accesses.
// Assumes: One core clock; the core gives strobes one cycle each and keeps
//          from reading through the stack pointer right after a limit write.
// Notes:   Outputs are registered, so answers appear one cycle after the
//          request cycle; the trap pulse is one cycle wide.
//          The limit register has no reset: load it before the first
//          stack use, or the limit checks compare against an unknown.
//          A pointer load wins over a push, and a push over a pop; the
//          losing request is dropped with no strobe and no trap.
// Function
// - Register region is byte addresses 0000h to 07FFh.
// - Unimplemented register-region addresses read as zero.
// - Implemented registers sit in aligned 32-byte blocks, one at least each.
// - Stack pointer holds first free word; stack grows upward.
// - Push writes at pointer then increments; pop decrements then reads.
// - Call pushes program counter with upper byte cleared.
// - Exception push puts status low byte in upper byte of PC word.
// - Stack limit not reset; its bit 0 is always zero.
// - Every stack-pointer effective address is compared against the limit.
// - Push at pointer equal to limit is fine; the next push traps.
// - Stack pointer address below 0800h raises a stack error trap.
// - Table address is 8-bit page above 16-bit effective address.
// - Table page bit 7 selects configuration memory, else user memory.
// - Address bit 15 set maps page plus low 15 bits to 23 bits.
// - Visibility accesses reach user program memory only.
// - Visibility accesses are read-only and return the low 16-bit word.
// - Table accesses read and write every byte of the program word.
// - Bit 15 clear goes to data memory, set goes to visibility window.
// - Reads outside implemented data memory return zero.
`timescale 1ns/1ps
`include "slpa_defs.vh"

module slpa_addr_unit #(
  parameter [63:0] IMPL_MAP  = 64'h0000_0000_0000_00ff,
  parameter [15:0] DATA_TOP  = 16'h0fff
) (
  // Clock and reset
  clk,
  rst_n,

  // Pointer, limit and page loads
  spWrite,
  spWrData,
  limWrite,
  limWrData,
  tblPageWrite,
  visPageWrite,
  pageWrData,

  // Stack requests and checks
  pushReq,
  pushKind,
  pushData,
  statusLowByte,
  popReq,
  spEaValid,
  spEa,

  // Data and table requests, read sources
  dataReq,
  dataWrite,
  dataEa,
  regRdData,
  memRdData,
  progRdWord,
  tblReq,
  tblWrite,
  tblEa,

  // Stack outputs
  stackPtr,
  stackLimit,
  stackWrAddr,
  stackWrData,
  stackWrEn,
  stackRdAddr,
  stackRdEn,
  stackTrap,

  // Table and data outputs
  tblAddr,
  tblCfgSel,
  tblUserSel,
  tblWrEn,
  tblRdEn,
  visAddr,
  visRdEn,
  visWrBlocked,
  dataRdData,
  regSel
);
  // Clock and reset
  input  wire        clk;
  input  wire        rst_n;

  // Pointer and limit loads
  input  wire        spWrite;
  input  wire [15:0] spWrData;
  input  wire        limWrite;
  input  wire [15:0] limWrData;

  // Page loads
  input  wire        tblPageWrite;
  input  wire        visPageWrite;
  input  wire [7:0]  pageWrData;

  // Push and pop requests
  input  wire        pushReq;
  input  wire [1:0]  pushKind;
  input  wire [23:0] pushData;
  input  wire [7:0]  statusLowByte;
  input  wire        popReq;

  // Stack-pointer effective address
  input  wire        spEaValid;
  input  wire [15:0] spEa;

  // Data access
  input  wire        dataReq;
  input  wire        dataWrite;
  input  wire [15:0] dataEa;

  // Read sources
  input  wire [15:0] regRdData;
  input  wire [15:0] memRdData;
  input  wire [23:0] progRdWord;

  // Table access
  input  wire        tblReq;
  input  wire        tblWrite;
  input  wire [15:0] tblEa;

  // Stack outputs
  output reg  [15:0] stackPtr;
  output reg  [15:0] stackLimit;
  output reg  [15:0] stackWrAddr;
  output reg  [15:0] stackWrData;
  output reg         stackWrEn;
  output reg  [15:0] stackRdAddr;
  output reg         stackRdEn;
  output reg         stackTrap;

  // Table outputs
  output reg  [23:0] tblAddr;
  output reg         tblCfgSel;
  output reg         tblUserSel;
  output reg         tblWrEn;
  output reg         tblRdEn;

  // Data-side outputs
  output reg  [22:0] visAddr;
  output reg         visRdEn;
  output reg         visWrBlocked;
  output reg  [15:0] dataRdData;
  output reg         regSel;

  // Push kinds
  localparam [1:0] KIND_DATA = 2'b00;
  localparam [1:0] KIND_CALL = 2'b01;
  localparam [1:0] KIND_EXC  = 2'b10;

  // Stack pointer and limit state
  reg  [15:0] sp_ff;
  reg  [15:0] nxt_sp;
  reg  [15:0] lim_ff;

  // Page registers
  reg  [7:0]  tblPage_ff;
  reg  [7:0]  visPage_ff;

  // Stack helpers
  reg  [15:0] pushWord;
  reg  [15:0] popAddr;
  reg         limitHit;
  reg         floorHit;
  wire        pushGo;
  wire        popGo;

  // Data-side helpers
  reg  [15:0] rdMux;
  wire        inRegion;
  wire        implBlock;

  // Register region decode for data reads
  slpa_region_map #(
    .IMPL_MAP (IMPL_MAP)
  ) u_region (
    .addr      (dataEa),
    .inRegion  (inRegion),
    .implBlock (implBlock)
  );

  // Request priority: pointer load, then push, then pop
  assign pushGo = pushReq & ~spWrite;
  assign popGo  = popReq & ~pushReq & ~spWrite;

  // Stack pointer next value: post-increment push, pre-decrement pop
  always @* begin
    nxt_sp  = sp_ff;
    popAddr = sp_ff - `SLPA_WORD_STEP;
    if (spWrite) begin
      nxt_sp = {spWrData[15:1], 1'b0};
    end else if (pushReq) begin
      nxt_sp = sp_ff + `SLPA_WORD_STEP;
    end else if (popReq) begin
      nxt_sp = popAddr;
    end
  end

  // Word pushed: call clears upper byte, exception inserts status byte
  always @* begin
    case (pushKind)
      KIND_CALL: pushWord = {8'h00, pushData[23:16]};
      KIND_EXC:  pushWord = {statusLowByte, pushData[23:16]};
      default:   pushWord = pushData[15:0];
    endcase
  end

  // Limit checks on pushes and on stack-pointer addresses
  always @* begin
    limitHit = 1'b0;
    if (pushGo && (sp_ff > lim_ff)) begin
      limitHit = 1'b1;
    end
    if (spEaValid && (spEa > lim_ff)) begin
      limitHit = 1'b1;
    end
  end

  // Floor checks trap stack accesses that reach into the register region
  always @* begin
    floorHit = 1'b0;
    if ((pushGo || popGo) && (sp_ff < `SLPA_STACK_FLOOR)) begin
      floorHit = 1'b1;
    end
    if (popGo && (popAddr < `SLPA_STACK_FLOOR)) begin
      floorHit = 1'b1;
    end
    if (spEaValid && (spEa < `SLPA_STACK_FLOOR)) begin
      floorHit = 1'b1;
    end
  end

  // Stack pointer and trap pulse
  always @(posedge clk) begin
    if (!rst_n) begin
      sp_ff       <= `SLPA_SP_RST;
      stackTrap   <= 1'b0;
    end else begin
      sp_ff       <= nxt_sp;
      stackTrap   <= limitHit | floorHit;
    end
  end

  // Stack memory strobes; a dropped request gives no strobe
  always @(posedge clk) begin
    if (!rst_n) begin
      stackWrEn   <= 1'b0;
      stackRdEn   <= 1'b0;
      stackWrAddr <= 16'h0000;
      stackWrData <= 16'h0000;
      stackRdAddr <= 16'h0000;
    end else begin
      stackWrEn   <= pushGo;
      stackRdEn   <= popGo;
      stackWrAddr <= sp_ff;
      stackWrData <= pushWord;
      stackRdAddr <= popAddr;
    end
  end

  // Limit register keeps bit 0 clear and has no reset value
  always @(posedge clk) begin
    if (limWrite) begin
      lim_ff <= {limWrData[15:1], 1'b0};
    end
  end

  // Page registers
  always @(posedge clk) begin
    if (!rst_n) begin
      tblPage_ff <= `SLPA_PAGE_RST;
      visPage_ff <= `SLPA_PAGE_RST;
    end else begin
      if (tblPageWrite) begin
        tblPage_ff <= pageWrData;
      end
      if (visPageWrite) begin
        visPage_ff <= pageWrData;
      end
    end
  end

  // Table access address and target select
  always @(posedge clk) begin
    if (!rst_n) begin
      tblAddr    <= 24'h000000;
      tblCfgSel  <= 1'b0;
      tblUserSel <= 1'b0;
      tblWrEn    <= 1'b0;
      tblRdEn    <= 1'b0;
    end else begin
      tblAddr    <= {tblPage_ff, tblEa};
      tblCfgSel  <= tblReq & tblPage_ff[`SLPA_CFG_BIT];
      tblUserSel <= tblReq & ~tblPage_ff[`SLPA_CFG_BIT];
      tblWrEn    <= tblReq & tblWrite;
      tblRdEn    <= tblReq & ~tblWrite;
    end
  end

  // Read data steering for the current data address
  always @* begin
    rdMux = 16'h0000;
    if (dataEa[`SLPA_VIS_BIT]) begin
      rdMux = progRdWord[15:0];
    end else if (inRegion) begin
      rdMux = implBlock ? regRdData : 16'h0000;
    end else if (dataEa <= DATA_TOP) begin
      rdMux = memRdData;
    end
  end

  // Data-side outputs and visibility window address
  always @(posedge clk) begin
    if (!rst_n) begin
      visAddr      <= 23'h000000;
      visRdEn      <= 1'b0;
      visWrBlocked <= 1'b0;
      dataRdData   <= 16'h0000;
      regSel       <= 1'b0;
    end else begin
      // 23-bit address never reaches the configuration half
      visAddr      <= {visPage_ff, dataEa[14:0]};
      visRdEn      <= dataReq & ~dataWrite & dataEa[`SLPA_VIS_BIT];
      visWrBlocked <= dataReq & dataWrite & dataEa[`SLPA_VIS_BIT];
      dataRdData   <= (dataReq & ~dataWrite) ? rdMux : 16'h0000;
      regSel       <= dataReq & implBlock;
    end
  end

  // Mirror internal registers to outputs
  always @* begin
    stackPtr   = sp_ff;
    stackLimit = lim_ff;
  end
endmodule // slpa_addr_unit

// ===== rtl/slpa_region_map.v
// Purpose: Decode the register region and flag implemented 32-byte blocks
// Assumes: Byte address from the core, same clock domain
// Notes:   Block map is a parameter; each set bit marks one 32-byte block
`timescale 1ns/1ps
`include "slpa_defs.vh"

module slpa_region_map #(
  parameter [63:0] IMPL_MAP = 64'h0
) (
  addr,
  inRegion,
  implBlock
);
  input  wire [15:0] addr;
  output wire        inRegion;
  output wire        implBlock;

  wire [5:0] blockIdx;

  // Region is the low 2 Kbytes of data space
  assign inRegion  = (addr <= `SLPA_REG_HI);
  // One flag per aligned 32-byte block
  assign blockIdx  = addr[`SLPA_REGION_MSB:`SLPA_REGION_LSB];
  assign implBlock = inRegion & IMPL_MAP[blockIdx];
endmodule // slpa_region_map

// ===== tb/slpa_addr_unit_checker.sv
// Purpose: Port assertions for the stack and address unit
// Assumes: One clock, sync active-low reset
// Notes:   Bound to every slpa_addr_unit instance
`timescale 1ns/1ps
module slpa_addr_unit_chk (
  input wire        clk,
  input wire        rst_n,
  input wire        spWrite,
  input wire        limWrite,
  input wire [15:0] limWrData,
  input wire        pushReq,
  input wire [1:0]  pushKind,
  input wire [23:0] pushData,
  input wire [7:0]  statusLowByte,
  input wire        popReq,
  input wire        spEaValid,
  input wire [15:0] spEa,
  input wire        tblReq,
  input wire [15:0] tblEa,
  input wire [15:0] stackPtr,
  input wire [15:0] stackLimit,
  input wire [15:0] stackWrAddr,
  input wire [15:0] stackWrData,
  input wire        stackWrEn,
  input wire [15:0] stackRdAddr,
  input wire        stackRdEn,
  input wire        stackTrap,
  input wire [23:0] tblAddr,
  input wire        tblCfgSel
);
  wire [7:0] pcHi   = pushData[23:16];
  wire       anyReq = pushReq | popReq | spEaValid;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Request steps of a stack access
  sequence s_push; pushReq && !spWrite; endsequence
  sequence s_pop; popReq && !pushReq && !spWrite; endsequence
  // Push writes at the pointer, pop reads below it
  property p_push;
    s_push |=> stackWrAddr == $past(stackPtr)
      && stackPtr == $past(stackPtr) + 16'h0002;
  endproperty
  a_push: assert property (p_push) else $error("push slot");
  property p_pop;
    s_pop |=> stackRdEn && stackRdAddr == stackPtr
      && stackPtr == $past(stackPtr) - 16'h0002;
  endproperty
  a_pop: assert property (p_pop) else $error("pop slot");
  // Requests losing to a pointer load give no strobe and no trap
  property p_drop;
    spWrite && !spEaValid && (pushReq || popReq)
      |=> !stackWrEn && !stackRdEn && !stackTrap;
  endproperty
  a_drop: assert property (p_drop) else $error("dropped req");
  // Upper byte of a pushed program counter
  property p_call;
    s_push ##0 pushKind == 2'h1 |=> stackWrData == {8'h00, $past(pcHi)};
  endproperty
  a_call: assert property (p_call) else $error("call byte");
  property p_exc;
    s_push ##0 pushKind == 2'h2
      |=> stackWrData == {$past(statusLowByte), $past(pcHi)};
  endproperty
  a_exc: assert property (p_exc) else $error("status byte");
  // Limit keeps its low bit clear
  property p_lim;
    limWrite |=> stackLimit == ($past(limWrData) & 16'hfffe);
  endproperty
  a_lim: assert property (p_lim) else $error("limit load");
  // Limit and floor checks
  property p_over;
    s_push ##0 stackPtr > stackLimit |=> stackTrap;
  endproperty
  a_over: assert property (p_over) else $error("no trap");
  property p_eqOk;
    s_push ##0 !spEaValid && stackPtr == stackLimit
      && stackPtr >= 16'h0800 |=> !stackTrap;
  endproperty
  a_eqOk: assert property (p_eqOk) else $error("early trap");
  property p_ea;
    spEaValid && (spEa > stackLimit || spEa < 16'h0800) |=> stackTrap;
  endproperty
  a_ea: assert property (p_ea) else $error("ea trap");
  property p_cause;
    stackTrap |-> $past(anyReq);
  endproperty
  a_cause: assert property (p_cause) else $error("stray trap");
  // Table address forming
  property p_tbl;
    tblReq |=> tblAddr[15:0] == $past(tblEa) && tblCfgSel == tblAddr[23];
  endproperty
  a_tbl: assert property (p_tbl) else $error("table addr");
endmodule // slpa_addr_unit_chk

bind slpa_addr_unit slpa_addr_unit_chk chk (.*);

// ===== tb/slpa_addr_unit_tb.sv
// Purpose: Self-checking bench for the address unit
// Assumes: Core model supplies read data
// Notes:   Seeded random traffic plus corners
`timescale 1ns/1ps
module slpa_addr_unit_tb;
  localparam [63:0] MAP = 64'h8000_0000_0000_0f0f;
  logic        clk, rst_n, spWrite, limWrite, tblPageWrite, visPageWrite;
  logic        pushReq, popReq, spEaValid, dataReq, dataWrite;
  logic        tblReq, tblWrite;
  logic [1:0]  pushKind;
  logic [7:0]  statusLowByte, pageWrData, st, tp, vp;
  logic [15:0] spWrData, limWrData, spEa, dataEa, tblEa, sp, lim;
  logic [23:0] pushData;
  wire  [15:0] regRdData, memRdData, stackPtr, stackLimit, stackWrAddr;
  wire  [15:0] stackWrData, stackRdAddr, dataRdData;
  wire  [23:0] progRdWord, tblAddr;
  wire  [22:0] visAddr;
  wire         stackWrEn, stackRdEn, stackTrap, tblCfgSel, tblUserSel;
  wire         tblWrEn, tblRdEn, visRdEn, visWrBlocked, regSel;
  logic [15:0] corner [10] = '{16'h0000, 16'h00e0, 16'h0100, 16'h07c0,
    16'h07fe, 16'h0800, 16'h0fff, 16'h1000, 16'h8000, 16'hffff};
  int          err_count = 0;
  int          compares = 0;
  slpa_addr_unit #(.IMPL_MAP(MAP), .DATA_TOP(16'h0fff)) uut (.*);
  slpa_core_model core (.*);
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic [15:0] expRd(input [15:0] a);
    if (a[15]) return a ^ 16'h0ff0;
    if (a < 16'h0800) return MAP[a[10:5]] ? a ^ 16'h5a5a : 16'h0000;
    return a <= 16'h0fff ? ~a : 16'h0000;
  endfunction
  // Close the request cycle and let the answer land
  task automatic step;
    @(posedge clk);
    {spWrite, limWrite, tblPageWrite, visPageWrite} <= 4'h0;
    {pushReq, popReq, spEaValid, dataReq, tblReq} <= 5'h00;
    #1;
  endtask
  task automatic spLoad(input [15:0] v, input logic isLim);
    @(posedge clk);
    {limWrite, spWrite, limWrData, spWrData} <= {isLim, !isLim, v, v};
    step;
    if (isLim) lim = v & 16'hfffe;
    else sp = v & 16'hfffe;
    chk(isLim ? stackLimit : stackPtr, v & 16'hfffe);
  endtask
  task automatic push(input [1:0] k, input [23:0] d);
    @(posedge clk);
    {pushReq, pushKind, pushData} <= {1'b1, k, d};
    step;
    chk(stackWrAddr, sp);
    chk(stackWrData, k == 2'h2 ? {st, d[23:16]} :
      k == 2'h1 ? {8'h00, d[23:16]} : d[15:0]);
    chk(stackTrap, sp > lim || sp < 16'h0800);
    chk(stackWrEn, 1'b1);
    sp += 16'h0002;
    chk(stackPtr, sp);
  endtask
  task automatic pop;
    @(posedge clk);
    popReq <= 1'b1;
    step;
    sp -= 16'h0002;
    chk(stackRdAddr, sp);
    chk(stackTrap, sp < 16'h0800);
    chk(stackRdEn, 1'b1);
    chk(stackPtr, sp);
  endtask
  task automatic spAddr(input [15:0] a);
    @(posedge clk);
    {spEaValid, spEa} <= {1'b1, a};
    step;
    chk(stackTrap, a > lim || a < 16'h0800);
  endtask
  task automatic page(input logic v, input [7:0] d);
    @(posedge clk);
    {visPageWrite, tblPageWrite, pageWrData} <= {v, !v, d};
    step;
    if (v) vp = d;
    else tp = d;
  endtask
  task automatic acc(input [15:0] a, input logic w);
    @(posedge clk);
    {dataReq, dataWrite, dataEa} <= {1'b1, w, a};
    step;
    if (!w) chk(dataRdData, expRd(a));
    else chk(dataRdData, 16'h0000);
    chk(regSel, !a[15] && a < 16'h0800 && MAP[a[10:5]]);
    chk({visRdEn, visWrBlocked}, {a[15] & !w, a[15] & w});
    if (a[15]) chk(visAddr, {vp, a[14:0]});
  endtask
  task automatic tbl(input [15:0] a, input logic w);
    @(posedge clk);
    {tblReq, tblWrite, tblEa} <= {1'b1, w, a};
    step;
    chk(tblAddr, {tp, a});
    chk({tblCfgSel, tblUserSel}, {tp[7], !tp[7]});
    chk({tblWrEn, tblRdEn}, {w, !w});
  endtask
  task automatic final_report;
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #(100 * 5000);
    err_count++;
    final_report;
  end
  // Main sequence
  initial begin
    {rst_n, spWrite, limWrite, tblPageWrite, visPageWrite} = 5'h00;
    {pushReq, popReq, spEaValid, dataReq, tblReq, dataWrite} = 6'h00;
    {tblWrite, spWrData, limWrData, spEa, dataEa, tblEa} = 81'h0;
    {pushKind, pushData, pageWrData} = 34'h0;
    void'($urandom(97));
    st = 8'($urandom);
    statusLowByte = st;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    spLoad(16'($urandom) | 16'h0001, 1'b1);
    spLoad(16'h0904, 1'b1); // next op is no stack read
    spLoad(16'h0901, 1'b0);
    push(2'h1, 24'($urandom));
    push(2'h2, 24'($urandom));
    push(2'h0, 24'($urandom));
    push(2'h0, 24'($urandom));
    spLoad(16'h0804, 1'b0);
    repeat (3) pop;
    page(1'b0, 8'h80);
    page(1'b1, 8'hff);
    foreach (corner[i]) begin
      acc(corner[i], 1'b0);
      tbl(corner[i], i[0]);
    end
    repeat (40) begin
      page(1'($urandom), 8'($urandom));
      acc(16'($urandom), 1'($urandom));
      tbl(16'($urandom), 1'($urandom));
      spAddr(16'($urandom));
    end
    // Reset in mid-run: pointer and pages return, limit keeps its value
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(stackPtr, 16'h0800);
    chk({stackTrap, stackWrEn, stackRdEn}, 3'h0);
    chk(stackLimit, lim);
    {sp, tp, vp} = {16'h0800, 16'h0000};
    @(posedge clk);
    rst_n <= 1'b1;
    tbl(16'h1234, 1'b0);
    push(2'h0, 24'($urandom));
    // A pointer load in the same cycle drops the push
    @(posedge clk);
    {spWrite, spWrData, pushReq, pushKind} <= {1'b1, 16'h0a00, 1'b1, 2'h0};
    step;
    sp = 16'h0a00;
    chk({stackWrEn, stackTrap}, 2'h0);
    chk(stackPtr, sp);
    final_report;
  end
endmodule // slpa_addr_unit_tb

// ===== tb/slpa_core_model.sv
// Purpose: Core side read sources for the address unit
// Assumes: Sources answer in the request cycle
// Notes:   Each source gives its own pattern of the address
`timescale 1ns/1ps
module slpa_core_model (
  input  wire [15:0] dataEa,
  output wire [15:0] regRdData,
  output wire [15:0] memRdData,
  output wire [23:0] progRdWord
);
  // Distinct patterns so a wrong source shows up
  assign regRdData  = dataEa ^ 16'h5a5a;
  assign memRdData  = ~dataEa;
  assign progRdWord = {8'hc3, dataEa ^ 16'h0ff0};
endmodule // slpa_core_model
